//--- shared/txs_pkg.sv
// txs_pkg: register map, field layout and reset values of the transmit channel state
// assumes: 32-bit apb, word aligned registers
`default_nettype none
package txs_pkg;
   // ***************************
   // register offsets
   // ***************************
   localparam logic [11:0] OFS_WORD0 = 12'h000;
   localparam logic [11:0] OFS_WORD1 = 12'h004;
   localparam logic [11:0] OFS_DESC = 12'h008;
   localparam logic [11:0] OFS_BUFADDR = 12'h00C;
   localparam logic [11:0] OFS_FLAGLEN = 12'h010;
   localparam logic [11:0] OFS_PKTLEN = 12'h014;
   // ***************************
   // field positions
   // ***************************
   localparam int IN_PACKET_BIT = 0;
   localparam int CUT_BIT = 1;
   localparam int PTR_LSB = 2;
   localparam int TAG_LSB = 24;
   localparam int LAST_BIT = 17;
   localparam int FIRST_BIT = 16;
   localparam int REM_LSB = 16;
   // ***************************
   // reset values, beat size and state encoding
   // ***************************
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] RESET_HALF = 16'h0000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [29:0] RESET_PTR = 30'h0000_0000;
   localparam logic [3:0] BYTES_PER_BEAT = 4'h4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_NEXT = 3'b100
   } txs_state_t;
endpackage : txs_pkg
`default_nettype wire

//--- verilog/txs_apb_slave.sv
// txs_apb_slave: apb handshake, zero wait states, error on unmapped offsets
// assumes: single clock, synchronous active high reset
`default_nettype none
module txs_apb_slave (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic mapped_in,
   output logic pready_out,
   output logic pslverr_out,
   output logic wr_strobe_out
);
   import txs_pkg::*;
   wire access = psel_in & ~penable_in;
   // ready every access phase, answered one cycle after setup
   assign pready_out = 1'b1;
   assign wr_strobe_out = 1'b0;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= access & ~mapped_in;
      end
   end
endmodule : txs_apb_slave
`default_nettype wire

//--- verilog/txs_channel.sv
// txs_channel: transmit dma channel state words with apb access and data stepping
// assumes: engine side gives one-cycle load and beat strobes on CLK_IN, truncation is worked out inside
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none
//
// Operation
// - keep 30-bit current descriptor word pointer
// - flag truncation inside non-last buffer
// - hold 32-bit current buffer byte address
// - carry 8-bit tag from first descriptor
// - bit 17 marks last buffer
// - bit 16 marks first buffer
// - low 16 bits count bytes left
// - upper 16 bits count bytes before truncation
// - load packet length from first descriptor
// - give stored length to trailer builder
// - in-packet flag in words zero and one
module txs_channel (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // descriptor load from the engine
   input wire logic DESC_LOAD_IN,
   input wire logic [29:0] DESC_PTR_IN,
   input wire logic [31:0] DESC_BUF_ADDR_IN,
   input wire logic [15:0] DESC_BUF_LEN_IN,
   input wire logic DESC_FIRST_IN,
   input wire logic DESC_LAST_IN,
   input wire logic [7:0] DESC_TAG_IN,
   input wire logic [15:0] DESC_PKT_LEN_IN,
   // data movement
   input wire logic BEAT_IN,
   input wire logic [2:0] BEAT_BYTES_IN,
   // status to the engine
   output logic BUFFER_DONE_OUT,
   output logic PACKET_DONE_OUT,
   output logic [15:0] TRAILER_LENGTH_OUT,
   output logic [7:0] TAG_OUT,
   output logic IN_PACKET_OUT
);
   import txs_pkg::*;
   // ***************************
   // state
   // ***************************
   logic [29:0] active_descriptor_pointer;
   logic cut_inside_middle_buffer;
   logic [31:0] active_buffer_byte_address;
   logic [7:0] packet_tag_byte;
   logic active_buffer_is_last;
   logic active_buffer_is_first;
   logic [15:0] active_buffer_bytes_left;
   logic [15:0] bytes_before_truncation;
   logic [15:0] packet_length;
   logic in_packet;
   txs_state_t state;
   txs_state_t next_state;
   // ***************************
   // bus decode
   // ***************************
   wire setup = PSEL_IN & ~PENABLE_IN;
   wire wr_access = PSEL_IN & PENABLE_IN & PWRITE_IN;
   wire hit_w0 = PADDR_IN == OFS_WORD0;
   wire hit_w1 = PADDR_IN == OFS_WORD1;
   wire hit_desc = PADDR_IN == OFS_DESC;
   wire hit_buf = PADDR_IN == OFS_BUFADDR;
   wire hit_flag = PADDR_IN == OFS_FLAGLEN;
   wire hit_len = PADDR_IN == OFS_PKTLEN;
   wire mapped = hit_w0 | hit_w1 | hit_desc | hit_buf | hit_flag | hit_len;
   wire wr_inpkt = wr_access & (hit_w0 | hit_w1);
   wire wr_desc = wr_access & hit_desc;
   wire wr_buf = wr_access & hit_buf;
   wire wr_flag = wr_access & hit_flag;
   wire wr_len = wr_access & hit_len;
   // reserved bits are simply not stored, so they read zero
   wire [31:0] word_inpkt = {31'h0000_0000, in_packet};
   wire [31:0] word_desc = {active_descriptor_pointer, cut_inside_middle_buffer, 1'b0};
   wire [31:0] word_flag = {packet_tag_byte, 6'h00, active_buffer_is_last,
      active_buffer_is_first, active_buffer_bytes_left};
   wire [31:0] word_len = {bytes_before_truncation, packet_length};
   wire [31:0] rd_mux = (hit_w0 | hit_w1) ? word_inpkt :
      hit_desc ? word_desc :
      hit_buf ? active_buffer_byte_address :
      hit_flag ? word_flag :
      hit_len ? word_len : RESET_WORD;
   logic bus_ready;
   txs_apb_slave u_apb (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .psel_in(PSEL_IN),
      .penable_in(PENABLE_IN),
      .mapped_in(mapped),
      .pready_out(bus_ready),
      .pslverr_out(PSLVERR_OUT),
      .wr_strobe_out()
   );
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         PRDATA_OUT <= RESET_WORD;
         PREADY_OUT <= 1'b0;
      end else begin
         PRDATA_OUT <= setup ? rd_mux : PRDATA_OUT;
         PREADY_OUT <= setup & bus_ready;
      end
   end
   // ***************************
   // data stepping
   // ***************************
   function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
      sat_sub = (a > b) ? a - b : 16'h0000;
   endfunction : sat_sub
   wire [15:0] beat_n = {13'h0000, BEAT_BYTES_IN};
   wire beat = BEAT_IN & (state == ST_SEND);
   wire [15:0] next_left = sat_sub(active_buffer_bytes_left, beat_n);
   wire [15:0] next_rem = sat_sub(bytes_before_truncation, beat_n);
   // truncation: allowance spent while buffer still holds bytes
   wire cut_now = beat & (next_rem == 16'h0000) & (next_left != 16'h0000);
   wire buf_end = beat & ((next_left == 16'h0000) | (next_rem == 16'h0000));
   wire pkt_end = buf_end & (active_buffer_is_last | (next_rem == 16'h0000));
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: next_state = DESC_LOAD_IN ? ST_SEND : ST_IDLE;
         ST_SEND: next_state = pkt_end ? ST_IDLE : (buf_end ? ST_NEXT : ST_SEND);
         ST_NEXT: next_state = DESC_LOAD_IN ? ST_SEND : ST_NEXT;
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state <= ST_IDLE;
         active_descriptor_pointer <= RESET_PTR;
         active_buffer_byte_address <= RESET_WORD;
         active_buffer_is_first <= 1'b0;
         active_buffer_is_last <= 1'b0;
         active_buffer_bytes_left <= RESET_HALF;
         packet_tag_byte <= RESET_BYTE;
         packet_length <= RESET_HALF;
         bytes_before_truncation <= RESET_HALF;
         cut_inside_middle_buffer <= 1'b0;
         in_packet <= 1'b0;
      end else begin
         state <= next_state;
         if (DESC_LOAD_IN) begin
            active_descriptor_pointer <= DESC_PTR_IN;
            active_buffer_byte_address <= DESC_BUF_ADDR_IN;
            active_buffer_bytes_left <= DESC_BUF_LEN_IN;
            active_buffer_is_first <= DESC_FIRST_IN;
            active_buffer_is_last <= DESC_LAST_IN;
         end else if (beat) begin
            active_buffer_byte_address <= active_buffer_byte_address + 32'(beat_n);
            active_buffer_bytes_left <= next_left;
         end else begin
            if (wr_desc) active_descriptor_pointer <= PWDATA_IN[31:PTR_LSB];
            if (wr_buf) active_buffer_byte_address <= PWDATA_IN;
            if (wr_flag) active_buffer_bytes_left <= PWDATA_IN[15:0];
            if (wr_flag) active_buffer_is_first <= PWDATA_IN[FIRST_BIT];
            if (wr_flag) active_buffer_is_last <= PWDATA_IN[LAST_BIT];
         end
         // first descriptor of a packet carries tag and length
         if (DESC_LOAD_IN & DESC_FIRST_IN) begin
            packet_tag_byte <= DESC_TAG_IN;
            packet_length <= DESC_PKT_LEN_IN;
            bytes_before_truncation <= DESC_PKT_LEN_IN;
            cut_inside_middle_buffer <= 1'b0;
         end else if (beat) begin
            bytes_before_truncation <= next_rem;
            cut_inside_middle_buffer <= cut_inside_middle_buffer
               | (cut_now & ~active_buffer_is_last);
         end else begin
            if (wr_flag) packet_tag_byte <= PWDATA_IN[31:TAG_LSB];
            if (wr_len) packet_length <= PWDATA_IN[15:0];
            if (wr_len) bytes_before_truncation <= PWDATA_IN[31:REM_LSB];
            if (wr_desc) cut_inside_middle_buffer <= PWDATA_IN[CUT_BIT];
         end
         // hardware set wins over a software write
         if (DESC_LOAD_IN & DESC_FIRST_IN) in_packet <= 1'b1;
         else if (pkt_end) in_packet <= 1'b0;
         else if (wr_inpkt) in_packet <= PWDATA_IN[IN_PACKET_BIT];
      end
   end
   // ***************************
   // engine outputs
   // ***************************
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         BUFFER_DONE_OUT <= 1'b0;
         PACKET_DONE_OUT <= 1'b0;
         TRAILER_LENGTH_OUT <= RESET_HALF;
         TAG_OUT <= RESET_BYTE;
         IN_PACKET_OUT <= 1'b0;
      end else begin
         BUFFER_DONE_OUT <= buf_end;
         PACKET_DONE_OUT <= pkt_end;
         TRAILER_LENGTH_OUT <= packet_length;
         TAG_OUT <= packet_tag_byte;
         IN_PACKET_OUT <= in_packet;
      end
   end
   // ***************************
   // checks
   // ***************************
   sequence s_first_load;
      DESC_LOAD_IN && DESC_FIRST_IN;
   endsequence
   a_ptr_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      DESC_LOAD_IN |=> active_descriptor_pointer == $past(DESC_PTR_IN))
      else $error("descriptor pointer not loaded");
   a_cut_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      cut_now && !active_buffer_is_last && !DESC_LOAD_IN |=> cut_inside_middle_buffer)
      else $error("truncation flag not set");
   a_addr_step: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      beat && !DESC_LOAD_IN |=>
      active_buffer_byte_address == $past(active_buffer_byte_address) + 32'($past(beat_n)))
      else $error("buffer address not advanced");
   a_tag_carry: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> ##1 TAG_OUT == $past(DESC_TAG_IN, 2))
      else $error("tag not carried");
   a_last_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      DESC_LOAD_IN |=> active_buffer_is_last == $past(DESC_LAST_IN))
      else $error("last flag wrong");
   a_first_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      DESC_LOAD_IN |=> word_flag[FIRST_BIT] == $past(DESC_FIRST_IN))
      else $error("first flag wrong");
   a_left_count: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      beat && !DESC_LOAD_IN |=> active_buffer_bytes_left == $past(next_left))
      else $error("bytes left not counted");
   a_rem_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> bytes_before_truncation == $past(DESC_PKT_LEN_IN))
      else $error("truncation allowance not loaded");
   a_len_trailer: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> ##1 TRAILER_LENGTH_OUT == $past(DESC_PKT_LEN_IN, 2))
      else $error("trailer length wrong");
   a_inpkt_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      pkt_end && !DESC_LOAD_IN |=> !in_packet ##1 !IN_PACKET_OUT || in_packet)
      else $error("in-packet flag not cleared");
   a_rsvd_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      PREADY_OUT && $past(hit_desc) |-> PRDATA_OUT[0] == 1'b0)
      else $error("reserved bit not zero");
   a_rsvd_inpkt: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      PREADY_OUT && $past(hit_w0 | hit_w1) |-> PRDATA_OUT[31:1] == 31'h0000_0000)
      else $error("in-packet word reserved bits set");
   a_rsvd_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      PREADY_OUT && $past(hit_flag) |-> PRDATA_OUT[23:18] == 6'h00)
      else $error("flag word reserved bits set");
   a_unmapped_err: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      PREADY_OUT && !$past(mapped) |-> PSLVERR_OUT && PRDATA_OUT == RESET_WORD)
      else $error("unmapped access not refused");
   // ***************************
   // checks: engine loads and steps
   // ***************************
   sequence s_trunc_beat;
      beat && next_rem == 16'h0000 && !DESC_LOAD_IN;
   endsequence
   sequence s_packet_closed;
      PACKET_DONE_OUT && BUFFER_DONE_OUT && !in_packet;
   endsequence
   a_buf_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      DESC_LOAD_IN |=> active_buffer_byte_address == $past(DESC_BUF_ADDR_IN))
      else $error("buffer address not loaded");
   a_left_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      DESC_LOAD_IN |=> active_buffer_bytes_left == $past(DESC_BUF_LEN_IN))
      else $error("buffer length not loaded");
   a_tag_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> packet_tag_byte == $past(DESC_TAG_IN))
      else $error("tag not loaded");
   a_len_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> packet_length == $past(DESC_PKT_LEN_IN))
      else $error("packet length not loaded");
   a_rem_step: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      beat && !(DESC_LOAD_IN && DESC_FIRST_IN) |=> bytes_before_truncation == $past(next_rem))
      else $error("truncation allowance not counted");
   a_cut_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> !cut_inside_middle_buffer)
      else $error("truncation flag not cleared");
   a_cut_last: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      beat && active_buffer_is_last && !cut_inside_middle_buffer && !DESC_LOAD_IN
      |=> !cut_inside_middle_buffer)
      else $error("truncation flag set in last buffer");
   a_inpkt_set: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_first_load |=> in_packet ##1 IN_PACKET_OUT)
      else $error("in-packet flag not set");
   a_buf_done: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      beat && next_left == 16'h0000 |=> BUFFER_DONE_OUT)
      else $error("buffer end not reported");
   a_pkt_last: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      beat && active_buffer_is_last && next_left == 16'h0000 |=> PACKET_DONE_OUT)
      else $error("packet end not reported");
   a_trunc_end: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_trunc_beat |=> s_packet_closed)
      else $error("truncation did not end packet");
   a_idle_beat: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      BEAT_IN && state != ST_SEND && !DESC_LOAD_IN && !wr_flag
      |=> $stable(active_buffer_bytes_left))
      else $error("beat counted outside send");
   // ***************************
   // checks: software writes and holds
   // ***************************
   a_wr_ptr: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_desc && !DESC_LOAD_IN && !beat |=> active_descriptor_pointer == $past(PWDATA_IN[31:2]))
      else $error("pointer write lost");
   a_wr_addr: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_buf && !DESC_LOAD_IN && !beat |=> active_buffer_byte_address == $past(PWDATA_IN))
      else $error("address write lost");
   a_wr_left: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_flag && !DESC_LOAD_IN && !beat |=> active_buffer_bytes_left == $past(PWDATA_IN[15:0]))
      else $error("buffer length write lost");
   a_wr_tag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_flag && !DESC_LOAD_IN && !beat |=> packet_tag_byte == $past(PWDATA_IN[31:24]))
      else $error("tag write lost");
   a_wr_len: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_len && !DESC_LOAD_IN && !beat |=> packet_length == $past(PWDATA_IN[15:0]))
      else $error("packet length write lost");
   a_wr_rem: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_len && !DESC_LOAD_IN && !beat |=> bytes_before_truncation == $past(PWDATA_IN[31:16]))
      else $error("allowance write lost");
   a_wr_inpkt: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      wr_inpkt && !DESC_LOAD_IN && !pkt_end |=> in_packet == $past(PWDATA_IN[0]))
      else $error("in-packet write lost");
   a_ptr_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !DESC_LOAD_IN && !wr_desc |=> $stable(active_descriptor_pointer))
      else $error("pointer moved");
   a_addr_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !DESC_LOAD_IN && !beat && !wr_buf |=> $stable(active_buffer_byte_address))
      else $error("address moved");
   a_first_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !DESC_LOAD_IN && !wr_flag |=> $stable(active_buffer_is_first))
      else $error("first flag moved");
   a_last_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !DESC_LOAD_IN && !wr_flag |=> $stable(active_buffer_is_last))
      else $error("last flag moved");
   a_tag_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !(DESC_LOAD_IN && DESC_FIRST_IN) && !wr_flag |=> $stable(packet_tag_byte))
      else $error("tag moved");
   a_len_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !(DESC_LOAD_IN && DESC_FIRST_IN) && !wr_len |=> $stable(packet_length))
      else $error("packet length moved");
endmodule : txs_channel
`default_nettype wire

//--- sim/txs_mem_model.sv
// txs_mem_model: descriptor memory and data mover on the far side of the channel
// assumes: go_in is a one-cycle pulse, beats run until the channel reports a buffer end
`default_nettype none
module txs_mem_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control from the bench
   input wire logic go_in,
   input wire logic idx_in,
   input wire logic stall_in,
   input wire logic last_in,
   input wire logic done_in,
   // descriptor and beats
   output logic load_out,
   output logic [29:0] ptr_out,
   output logic [31:0] addr_out,
   output logic [15:0] len_out,
   output logic first_out,
   output logic last_out,
   output logic [7:0] tag_out,
   output logic [15:0] pkt_out,
   output logic beat_out
);
   // ***************************
   // two-entry descriptor table
   // ***************************
   logic busy;
   logic [29:0] p;
   logic [31:0] a;
   logic [15:0] n;
   assign p = idx_in ? 30'h0000_1240 : 30'h0000_1234;
   assign a = idx_in ? 32'h8000_0200 : 32'h8000_0100;
   assign n = idx_in ? 16'h0010 : 16'h0008;
   // idle lines show the inverse, so a stale capture cannot pass
   assign ptr_out = load_out ? p : ~p;
   assign addr_out = load_out ? a : ~a;
   assign len_out = load_out ? n : ~n;
   assign first_out = load_out ? ~idx_in : idx_in;
   assign last_out = load_out ? last_in : ~last_in;
   assign tag_out = load_out ? 8'hA5 : 8'h5A;
   assign pkt_out = load_out ? 16'h0014 : 16'hFFEB;
   // stops at the done pulse, never counts bytes for the channel
   assign beat_out = busy & ~stall_in & ~done_in;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         load_out <= 1'b0;
         busy <= 1'b0;
      end else begin
         load_out <= go_in;
         busy <= load_out | (busy & ~done_in);
      end
   end
endmodule : txs_mem_model
`default_nettype wire

//--- sim/tx_dma_channel_state_tb.sv
// tx_dma_channel_state_tb: apb master, register checks and two-buffer packet run
// assumes: zero-wait apb slave, descriptor model in txs_mem_model
`default_nettype none
module tx_dma_channel_state_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import txs_pkg::*;
   typedef struct packed {logic rd; logic [31:0] d; logic err;} txs_note_t;
   // ***************************
   // signals
   // ***************************
   logic CLK_IN, RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
   logic [11:0] PADDR_IN;
   logic [31:0] PWDATA_IN, PRDATA_OUT, DESC_BUF_ADDR_IN, r;
   logic [29:0] DESC_PTR_IN;
   logic [15:0] DESC_BUF_LEN_IN, DESC_PKT_LEN_IN, TRAILER_LENGTH_OUT;
   logic [7:0] DESC_TAG_IN, TAG_OUT;
   logic DESC_LOAD_IN, DESC_FIRST_IN, DESC_LAST_IN, BEAT_IN;
   logic BUFFER_DONE_OUT, PACKET_DONE_OUT, IN_PACKET_OUT, go, idx, stall, lst;
   logic [2:0] nb;
   int k = 0;
   txs_note_t notes[$];
   txs_note_t note;
   int n_fail = 0;
   int checked = 0;
   int seed = 13444;
   int cyc = 0;
   localparam logic [31:0] MSK [6] = '{32'h0000_0001, 32'h0000_0001, 32'hFFFF_FFFE,
      32'hFFFF_FFFF, 32'hFF03_FFFF, 32'hFFFF_FFFF};
   txs_channel dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
      .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
      .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .DESC_LOAD_IN(DESC_LOAD_IN), .DESC_PTR_IN(DESC_PTR_IN),
      .DESC_BUF_ADDR_IN(DESC_BUF_ADDR_IN), .DESC_BUF_LEN_IN(DESC_BUF_LEN_IN),
      .DESC_FIRST_IN(DESC_FIRST_IN), .DESC_LAST_IN(DESC_LAST_IN), .DESC_TAG_IN(DESC_TAG_IN),
      .DESC_PKT_LEN_IN(DESC_PKT_LEN_IN), .BEAT_IN(BEAT_IN), .BEAT_BYTES_IN(nb),
      .BUFFER_DONE_OUT(BUFFER_DONE_OUT), .PACKET_DONE_OUT(PACKET_DONE_OUT),
      .TRAILER_LENGTH_OUT(TRAILER_LENGTH_OUT), .TAG_OUT(TAG_OUT),
      .IN_PACKET_OUT(IN_PACKET_OUT));
   txs_mem_model mem (.clk_in(CLK_IN), .rst_in(RST_IN), .go_in(go), .idx_in(idx),
      .stall_in(stall), .last_in(lst), .done_in(BUFFER_DONE_OUT), .load_out(DESC_LOAD_IN),
      .ptr_out(DESC_PTR_IN), .addr_out(DESC_BUF_ADDR_IN), .len_out(DESC_BUF_LEN_IN),
      .first_out(DESC_FIRST_IN), .last_out(DESC_LAST_IN), .tag_out(DESC_TAG_IN),
      .pkt_out(DESC_PKT_LEN_IN), .beat_out(BEAT_IN));
   // ***************************
   // tasks
   // ***************************
   task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task conclude;
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
      input logic err);
      @(posedge CLK_IN);
      PSEL_IN <= 1'b1;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= d;
      notes.push_back('{~w, e, err});
      @(posedge CLK_IN);
      PENABLE_IN <= 1'b1;
      do @(posedge CLK_IN); while (PREADY_OUT !== 1'b1);
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
   endtask : apb
   // ***************************
   // clock, watchdog, monitor
   // ***************************
   initial begin
      CLK_IN = 1'b0;
      forever #10 CLK_IN = ~CLK_IN;
   end
   // 3000 cycles is several times the whole sequence
   always @(posedge CLK_IN) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end
   always @(posedge CLK_IN) begin
      if (PREADY_OUT === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         cmp("pslverr", 32'(note.err), 32'(PSLVERR_OUT));
         if (note.rd)
            cmp("prdata", note.d, PRDATA_OUT);
      end
   end
   // ***************************
   // main sequence
   // ***************************
   initial begin
      RST_IN = 1'b1;
      {PSEL_IN, PENABLE_IN, PWRITE_IN, go, idx, stall} = 6'b00_0001;
      PADDR_IN = 12'h000;
      PWDATA_IN = 32'h0000_0000;
      lst = 1'b0;
      nb = 3'h4;
      repeat (2) @(posedge CLK_IN);
      RST_IN <= 1'b0;
      for (int i = 0; i < 6; i++) apb(1'b0, 12'(4 * i), 32'h0, 32'h0, 1'b0);
      apb(1'b1, 12'h018, 32'hFFFF_FFFF, 32'h0, 1'b1);
      apb(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         apb(1'b1, 12'(4 * i), r, 32'h0, 1'b0);
         apb(1'b0, 12'(4 * i), 32'h0, r & MSK[i], 1'b0);
      end
      apb(1'b1, OFS_DESC, 32'h0, 32'h0, 1'b0);
      go <= 1'b1;
      @(posedge CLK_IN);
      go <= 1'b0;
      apb(1'b0, OFS_DESC, 32'h0, 32'h0000_48D0, 1'b0);
      apb(1'b0, OFS_BUFADDR, 32'h0, 32'h8000_0100, 1'b0);
      apb(1'b0, OFS_FLAGLEN, 32'h0, 32'hA501_0008, 1'b0);
      apb(1'b0, OFS_PKTLEN, 32'h0, 32'h0014_0014, 1'b0);
      apb(1'b0, OFS_WORD1, 32'h0, 32'h0000_0001, 1'b0);
      cmp("trailer", 32'h14, 32'(TRAILER_LENGTH_OUT));
      cmp("tag", 32'hA5, 32'(TAG_OUT));
      stall <= 1'b0;
      for (int i = 0; i < 50 && BUFFER_DONE_OUT !== 1'b1; i++) @(posedge CLK_IN);
      cmp("packet done", 32'h0, 32'(PACKET_DONE_OUT));
      cmp("buffer done", 32'h1, 32'(BUFFER_DONE_OUT));
      apb(1'b0, OFS_BUFADDR, 32'h0, 32'h8000_0108, 1'b0);
      apb(1'b0, OFS_FLAGLEN, 32'h0, 32'hA501_0000, 1'b0);
      apb(1'b0, OFS_PKTLEN, 32'h0, 32'h000C_0014, 1'b0);
      apb(1'b0, OFS_WORD0, 32'h0, 32'h0000_0001, 1'b0);
      idx <= 1'b1;
      go <= 1'b1;
      @(posedge CLK_IN);
      go <= 1'b0;
      for (int i = 0; i < 50 && PACKET_DONE_OUT !== 1'b1; i++) @(posedge CLK_IN);
      cmp("packet done", 32'h1, 32'(PACKET_DONE_OUT));
      apb(1'b0, OFS_DESC, 32'h0, 32'h0000_4902, 1'b0);
      apb(1'b0, OFS_BUFADDR, 32'h0, 32'h8000_020C, 1'b0);
      apb(1'b0, OFS_FLAGLEN, 32'h0, 32'hA500_0004, 1'b0);
      apb(1'b0, OFS_PKTLEN, 32'h0, 32'h0000_0014, 1'b0);
      apb(1'b0, OFS_WORD0, 32'h0, 32'h0000_0000, 1'b0);
      cmp("in packet", 32'h0, 32'(IN_PACKET_OUT));
      // single last buffer with a random beat size, ends on the last flag
      idx <= 1'b0;
      lst <= 1'b1;
      nb <= 3'(1 + $unsigned($random(seed)) % 7);
      go <= 1'b1;
      @(posedge CLK_IN);
      go <= 1'b0;
      for (int i = 0; i < 50 && PACKET_DONE_OUT !== 1'b1; i++) @(posedge CLK_IN);
      cmp("packet done", 32'h1, 32'(PACKET_DONE_OUT));
      cmp("buffer done", 32'h1, 32'(BUFFER_DONE_OUT));
      k = nb * ((8 + nb - 1) / nb);
      apb(1'b0, OFS_DESC, 32'h0, 32'h0000_48D0, 1'b0);
      apb(1'b0, OFS_BUFADDR, 32'h0, 32'h8000_0100 + 32'(k), 1'b0);
      apb(1'b0, OFS_FLAGLEN, 32'h0, 32'hA503_0000, 1'b0);
      apb(1'b0, OFS_PKTLEN, 32'h0, {16'h0014 - 16'(k), 16'h0014}, 1'b0);
      apb(1'b0, OFS_WORD1, 32'h0, 32'h0000_0000, 1'b0);
      repeat (3) @(posedge CLK_IN);
      conclude();
   end
endmodule : tx_dma_channel_state_tb
`default_nettype wire
